// ==== include/dlc_pkg.sv ====
// Constants and decode helpers for the link configuration register group.
// Assumes one byte-wide register port and the recovered pixel clock.
`default_nettype none
package dlc_pkg;
    localparam logic [7:0] ADDR_STRAP   = 8'h37;
    localparam logic [7:0] ADDR_DIVSEL  = 8'h3A;
    localparam logic [7:0] ADDR_EQ      = 8'h3B;
    localparam logic [7:0] ADDR_THR     = 8'h41;
    localparam logic [7:0] ADDR_BC      = 8'h43;

    localparam logic [7:0] STRAP_RESET  = 8'h00;
    localparam logic [7:0] DIVSEL_RESET = 8'h00;
    localparam logic [7:0] THR_RESET    = 8'h03;
    localparam logic [7:0] BC_RESET     = 8'h00;

    // Bit 3 of the divider register is read-only zero
    localparam logic [7:0] DIVSEL_WMASK = 8'hF7;
    localparam logic [7:0] EQ_RMASK     = 8'h3F;

    localparam int DONE1_BIT     = 7;
    localparam int DONE0_BIT     = 3;
    localparam int VAL1_LSB      = 4;
    localparam int VAL0_LSB      = 0;
    localparam int OVR_OUT_BIT   = 7;
    localparam int OUT_SEL_LSB   = 4;
    localparam int OVR_IN_BIT    = 2;
    localparam int IN_SEL_LSB    = 0;
    localparam int ERR_EN_BIT    = 4;
    localparam int THR_LSB       = 0;
    localparam int MISO_MODE_BIT = 4;
    localparam int POL_BIT       = 3;
    localparam int MODE_LSB      = 0;

    localparam logic [2:0] BC_NORMAL_GPIO = 3'b000;
    localparam logic [2:0] BC_HS_GPIO1    = 3'b001;
    localparam logic [2:0] BC_HS_GPIO2    = 3'b010;
    localparam logic [2:0] BC_HS_GPIO4    = 3'b011;
    localparam logic [2:0] BC_NORMAL_FSPI = 3'b100;
    localparam logic [2:0] BC_HS_FSPI     = 3'b101;
    localparam logic [2:0] BC_RESERVED    = 3'b110;
    localparam logic [2:0] BC_HS_RSPI     = 3'b111;

    function automatic logic [5:0] dlc_out_ratio(input logic [2:0] sel);
        case (sel)
            3'b000:  dlc_out_ratio = 6'h20;
            3'b001:  dlc_out_ratio = 6'h10;
            3'b010:  dlc_out_ratio = 6'h08;
            3'b011:  dlc_out_ratio = 6'h04;
            3'b100,
            3'b101:  dlc_out_ratio = 6'h02;
            default: dlc_out_ratio = 6'h01;
        endcase
    endfunction

    function automatic logic [3:0] dlc_in_ratio(input logic [1:0] sel);
        case (sel)
            2'b00:   dlc_in_ratio = 4'h1;
            2'b01:   dlc_in_ratio = 4'h2;
            2'b10:   dlc_in_ratio = 4'h4;
            default: dlc_in_ratio = 4'h8;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== rtl/dlc_link_config_regs.sv ====
// Link configuration and status registers, error-threshold lock logic,
// divider override muxing and reverse-tunnel MISO driver.
// Assumes an on-chip serial target engine presents byte register accesses
// on the pixel clock; strap, select and SPI clock inputs are asynchronous.
//
// Overview of operation
// - Second strap done flag bit 7 sets once its 3-bit value latches.
// - First strap done flag bit 3 sets once its 3-bit value latches.
// - Output divider override bit 7 replaces the automatic selection.
// - Output divider codes give 32,16,8,4,2,2,1,1.
// - Input divider override bit 2 replaces the synthesizer state machine choice.
// - Input divider codes give 1,2,4,8.
// - Bit 4 enables link error counting against the threshold.
// - Counter runs on pixel clock; 4-bit threshold resets to three.
// - Errors from both link clocks and control/audio channel all count.
// - Counting enabled, lock drops when count reaches the threshold.
// - Counting disabled, lock drops on the first error.
// - Reverse SPI tunnelling makes the device drive MISO.
// - Bit 4 set tristates MISO while select is deasserted.
// - Polarity bit 3 picks launch and sample SPI clock edges.
// - Three-bit mode field enables high-speed back-channel signalling.
// - GPIO modes are normal, one, two and four high-speed GPIOs.
// - SPI modes are normal forward, high-speed forward, high-speed reverse.
// - Second port select routes equalizer level reads to the second port level.
`timescale 1ns/1ps
`default_nettype none
module dlc_link_config_regs
    import dlc_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic       i_second_port_select,
    input  wire logic       i_strap0_done,
    input  wire logic [2:0] i_strap0_value,
    input  wire logic       i_strap1_done,
    input  wire logic [2:0] i_strap1_value,
    input  wire logic [2:0] i_auto_out_divider_select,
    input  wire logic [1:0] i_auto_in_divider_select,
    input  wire logic [5:0] i_equalizer_level0,
    input  wire logic [5:0] i_equalizer_level1,
    input  wire logic       i_link_detect,
    input  wire logic       i_err_link_clock_primary,
    input  wire logic       i_err_link_clock_secondary,
    input  wire logic       i_err_control_audio_channel,
    input  wire logic       i_spi_sclk,
    input  wire logic       i_spi_ss_n,
    input  wire logic       i_tunnel_miso,
    output logic [7:0]      o_reg_rdata,
    output logic [5:0]      o_out_divide_ratio,
    output logic [3:0]      o_in_divide_ratio,
    output logic            o_lock,
    output logic [2:0]      o_backchannel_mode,
    output logic            o_spi_edge_polarity,
    output logic            o_spi_miso,
    output logic            o_spi_miso_oe_n
);
    typedef struct packed {
        logic       d0_s1;
        logic       d0_s2;
        logic [2:0] v0_s1;
        logic [2:0] v0_s2;
        logic       d1_s1;
        logic       d1_s2;
        logic [2:0] v1_s1;
        logic [2:0] v1_s2;
        logic       ss_s1;
        logic       ss_s2;
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_prev;
        logic [7:0] strap;
        logic [7:0] divsel;
        logic [7:0] thr;
        logic [7:0] bc;
        logic [4:0] err_cnt;
        logic       lost;
        logic       lock;
        logic [7:0] rdata;
        logic [5:0] out_ratio;
        logic [3:0] in_ratio;
        logic       miso;
        logic       miso_oe_n;
    } dlc_state_t;

    dlc_state_t state_reg;
    dlc_state_t state_next;

    logic [1:0] err_hits;
    logic [4:0] err_sum;
    logic       any_err;
    logic       launch;
    logic       reverse;

    always_comb begin
        state_next = state_reg;
        err_hits = 2'({1'b0, i_err_link_clock_primary})
                 + 2'({1'b0, i_err_link_clock_secondary})
                 + 2'({1'b0, i_err_control_audio_channel});
        any_err = (err_hits != 2'h0);
        err_sum = state_reg.err_cnt + 5'({3'h0, err_hits});
        reverse = (state_reg.bc[MODE_LSB +: 3] == BC_HS_RSPI);
        if (state_reg.bc[POL_BIT]) begin
            launch = state_reg.sck_s2 & ~state_reg.sck_prev;
        end else begin
            launch = ~state_reg.sck_s2 & state_reg.sck_prev;
        end

        // Second stage only reads the first
        state_next.d0_s1 = i_strap0_done;
        state_next.d0_s2 = state_reg.d0_s1;
        state_next.v0_s1 = i_strap0_value;
        state_next.v0_s2 = state_reg.v0_s1;
        state_next.d1_s1 = i_strap1_done;
        state_next.d1_s2 = state_reg.d1_s1;
        state_next.v1_s1 = i_strap1_value;
        state_next.v1_s2 = state_reg.v1_s1;
        state_next.ss_s1 = i_spi_ss_n;
        state_next.ss_s2 = state_reg.ss_s1;
        state_next.sck_s1 = i_spi_sclk;
        state_next.sck_s2 = state_reg.sck_s1;
        state_next.sck_prev = state_reg.sck_s2;

        // Value is captured once; later pin wiggle is ignored
        if (state_reg.d0_s2 && !state_reg.strap[DONE0_BIT]) begin
            state_next.strap[VAL0_LSB +: 3] = state_reg.v0_s2;
            state_next.strap[DONE0_BIT] = 1'b1;
        end
        if (state_reg.d1_s2 && !state_reg.strap[DONE1_BIT]) begin
            state_next.strap[VAL1_LSB +: 3] = state_reg.v1_s2;
            state_next.strap[DONE1_BIT] = 1'b1;
        end

        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_DIVSEL: state_next.divsel = i_reg_wdata & DIVSEL_WMASK;
                ADDR_THR:    state_next.thr = i_reg_wdata;
                ADDR_BC:     state_next.bc = i_reg_wdata;
                default:     state_next.divsel = state_next.divsel;
            endcase
        end

        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_STRAP:  state_next.rdata = state_reg.strap;
                ADDR_DIVSEL: state_next.rdata = state_reg.divsel;
                ADDR_EQ: begin
                    if (i_second_port_select) begin
                        state_next.rdata = {2'h0, i_equalizer_level1};
                    end else begin
                        state_next.rdata = {2'h0, i_equalizer_level0};
                    end
                end
                ADDR_THR:    state_next.rdata = state_reg.thr;
                ADDR_BC:     state_next.rdata = state_reg.bc;
                default:     state_next.rdata = 8'h00;
            endcase
        end

        if (state_reg.divsel[OVR_OUT_BIT]) begin
            state_next.out_ratio = dlc_out_ratio(state_reg.divsel[OUT_SEL_LSB +: 3]);
        end else begin
            state_next.out_ratio = dlc_out_ratio(i_auto_out_divider_select);
        end
        if (state_reg.divsel[OVR_IN_BIT]) begin
            state_next.in_ratio = dlc_in_ratio(state_reg.divsel[IN_SEL_LSB +: 2]);
        end else begin
            state_next.in_ratio = dlc_in_ratio(i_auto_in_divider_select);
        end

        // Losing the link detect rearms lock and clears the count
        if (!i_link_detect) begin
            state_next.err_cnt = 5'h00;
            state_next.lost = 1'b0;
        end else if (any_err && !state_reg.lost) begin
            if (state_reg.thr[ERR_EN_BIT]) begin
                state_next.err_cnt = err_sum;
                if (err_sum >= {1'b0, state_reg.thr[THR_LSB +: 4]}) begin
                    state_next.lost = 1'b1;
                end
            end else begin
                state_next.lost = 1'b1;
            end
        end
        state_next.lock = i_link_detect & ~state_next.lost;

        state_next.bc[7:5] = state_next.bc[7:5];
        // Launch only on the selected edge, so the far end samples settled data
        if (launch) begin
            state_next.miso = i_tunnel_miso;
        end
        state_next.miso_oe_n = ~(reverse
            & (~state_reg.bc[MISO_MODE_BIT] | ~state_reg.ss_s2));
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_reg <= '0;
            state_reg.strap <= STRAP_RESET;
            state_reg.divsel <= DIVSEL_RESET;
            state_reg.thr <= THR_RESET;
            state_reg.bc <= BC_RESET;
            state_reg.ss_s1 <= 1'b1;
            state_reg.ss_s2 <= 1'b1;
            state_reg.miso_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_reg_rdata = state_reg.rdata;
    assign o_out_divide_ratio = state_reg.out_ratio;
    assign o_in_divide_ratio = state_reg.in_ratio;
    assign o_lock = state_reg.lock;
    assign o_backchannel_mode = state_reg.bc[MODE_LSB +: 3];
    assign o_spi_edge_polarity = state_reg.bc[POL_BIT];
    assign o_spi_miso = state_reg.miso;
    assign o_spi_miso_oe_n = state_reg.miso_oe_n;
endmodule
`default_nettype wire

// ==== tb/dlc_link_config_regs_properties.sv ====
// Port checker for the link configuration register group.
// Assumes one pixel clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dlc_link_config_regs_properties
    import dlc_pkg::*;
(
    input wire logic       i_mclk,
    input wire logic       i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic       i_second_port_select,
    input wire logic [5:0] i_equalizer_level0,
    input wire logic [5:0] i_equalizer_level1,
    input wire logic       i_link_detect,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_lock,
    input wire logic [2:0] o_backchannel_mode,
    input wire logic       o_spi_edge_polarity,
    input wire logic       o_spi_miso_oe_n
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd(a); i_reg_rd && i_reg_addr == a; endsequence
    sequence s_bc_wr; i_reg_wr && i_reg_addr == ADDR_BC; endsequence
    property p_strap1; s_rd(ADDR_STRAP) |=> o_reg_rdata[7] || o_reg_rdata[6:4] == 3'h0; endproperty
    property p_strap0; s_rd(ADDR_STRAP) |=> o_reg_rdata[3] || o_reg_rdata[2:0] == 3'h0; endproperty
    property p_div_rsvd; s_rd(ADDR_DIVSEL) |=> o_reg_rdata[3] == 1'b0; endproperty
    property p_eq;
        s_rd(ADDR_EQ) |=> o_reg_rdata == {2'h0, $past(i_second_port_select) ?
            $past(i_equalizer_level1) : $past(i_equalizer_level0)};
    endproperty
    property p_pol; s_bc_wr |=> o_spi_edge_polarity == $past(i_reg_wdata[3]); endproperty
    property p_mode; s_bc_wr |=> o_backchannel_mode == $past(i_reg_wdata[2:0]); endproperty
    property p_oe; (o_backchannel_mode != BC_HS_RSPI) [*3] |-> o_spi_miso_oe_n; endproperty
    property p_lock; $rose(o_lock) |-> $past(i_link_detect); endproperty
    a_strap1: assert property (p_strap1) else $error("strap1 value without done");
    a_strap0: assert property (p_strap0) else $error("strap0 value without done");
    a_div_rsvd: assert property (p_div_rsvd) else $error("divider bit 3 set");
    a_eq: assert property (p_eq) else $error("equalizer port mismatch");
    a_pol: assert property (p_pol) else $error("polarity not stored");
    a_mode: assert property (p_mode) else $error("mode not stored");
    a_oe: assert property (p_oe) else $error("miso driven outside reverse mode");
    a_lock: assert property (p_lock) else $error("lock without link");
endmodule
`default_nettype wire

// ==== tb/dlc_spi_host_model.sv ====
// SPI host and back-channel data source facing the reverse tunnel.
// Assumes the bench clock; all outputs move on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module dlc_spi_host_model (
    input  wire logic i_mclk,
    input  wire logic i_go,
    input  wire logic i_pol,
    output logic      o_sclk,
    output logic      o_ss_n,
    output logic      o_data
);
    logic [2:0] div_reg = 3'h0;
    initial begin
        o_sclk = 1'b0;
        o_ss_n = 1'b1;
        o_data = 1'b0;
    end
    always @(negedge i_mclk) begin
        div_reg <= div_reg + 3'h1;
        o_ss_n <= !i_go;
        if (!i_go) begin
            // Clock stands still; data churns so stale bits never match
            o_sclk <= 1'b0;
            o_data <= !o_data;
        end else if (div_reg == 3'h7) begin
            o_sclk <= !o_sclk;
            if (o_sclk == i_pol) o_data <= !o_data;
        end
    end
endmodule
`default_nettype wire

// ==== tb/dlc_link_config_regs_bench.sv ====
// Self-checking bench for the link configuration register group.
// Assumes the SPI host model and the port checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module dlc_link_config_regs_bench;
    import dlc_pkg::*;
    logic i_mclk = 1'b0, i_rst_n, i_reg_wr, i_reg_rd, i_second_port_select, i_strap0_done;
    logic i_strap1_done, i_link_detect, i_err_link_clock_primary, i_err_link_clock_secondary;
    logic i_err_control_audio_channel, i_spi_sclk, i_spi_ss_n, i_tunnel_miso, go;
    logic o_lock, o_spi_edge_polarity, o_spi_miso, o_spi_miso_oe_n;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [2:0] i_strap0_value, i_strap1_value, i_auto_out_divider_select, o_backchannel_mode;
    logic [1:0] i_auto_in_divider_select;
    logic [5:0] i_equalizer_level0, i_equalizer_level1, o_out_divide_ratio;
    logic [3:0] o_in_divide_ratio;
    logic [5:0] out_ratio [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01};
    int bad_count = 0, samples_checked = 0, cycles = 0;
    dlc_link_config_regs uut (.*);
    dlc_spi_host_model host (.i_mclk(i_mclk), .i_go(go), .i_pol(1'b0), .o_sclk(i_spi_sclk),
                             .o_ss_n(i_spi_ss_n), .o_data(i_tunnel_miso));
    initial forever #2.5 i_mclk = !i_mclk;
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        // Whole sequence needs about 150 cycles
        if (cycles == 8000) begin
            bad_count++;
            conclude;
        end
    end
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_mclk);
        i_reg_rd = 1'b0;
        @(negedge i_mclk);
        chk(o_reg_rdata === e, "read data");
    endtask
    initial begin
        {i_rst_n, i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd, i_second_port_select,
         i_strap0_done, i_strap0_value, i_strap1_done, i_strap1_value, i_link_detect,
         i_auto_out_divider_select, i_auto_in_divider_select, i_equalizer_level0,
         i_equalizer_level1, i_err_link_clock_primary, i_err_link_clock_secondary,
         i_err_control_audio_channel, go} = '0;
        repeat (6) @(negedge i_mclk);
        i_rst_n = 1'b1;
        rd(ADDR_STRAP, STRAP_RESET);
        rd(ADDR_DIVSEL, DIVSEL_RESET);
        rd(ADDR_EQ, 8'h00);
        rd(ADDR_THR, THR_RESET);
        rd(ADDR_BC, BC_RESET);
        rd(8'h50, 8'h00);
        i_auto_out_divider_select = 3'h2;
        i_auto_in_divider_select = 2'h1;
        repeat (2) @(negedge i_mclk);
        chk(o_out_divide_ratio === 6'h08, "auto out ratio");
        chk(o_in_divide_ratio === 4'h2, "auto in ratio");
        wr(ADDR_DIVSEL, 8'hFF);
        rd(ADDR_DIVSEL, DIVSEL_WMASK);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_DIVSEL, {1'b1, 3'(k), 2'b01, 2'(k)});
            @(negedge i_mclk);
            chk(o_out_divide_ratio === out_ratio[k], "out ratio");
            chk(o_in_divide_ratio === 4'(1 << k[1:0]), "in ratio");
        end
        i_strap1_value = 3'h5;
        i_strap0_value = 3'h6;
        {i_strap1_done, i_strap0_done} = 2'h3;
        repeat (4) @(negedge i_mclk);
        wr(ADDR_STRAP, 8'h00);
        rd(ADDR_STRAP, 8'hDE);
        i_equalizer_level0 = 6'h15;
        i_equalizer_level1 = 6'h2A;
        rd(ADDR_EQ, 8'h15);
        i_second_port_select = 1'b1;
        rd(ADDR_EQ, 8'h2A);
        wr(ADDR_THR, 8'h13);
        rd(ADDR_THR, 8'h13);
        i_link_detect = 1'b1;
        repeat (2) @(negedge i_mclk);
        {i_err_link_clock_primary, i_err_link_clock_secondary} = 2'h3;
        @(negedge i_mclk);
        {i_err_link_clock_primary, i_err_link_clock_secondary} = 2'h0;
        i_err_control_audio_channel = 1'b1;
        chk(o_lock === 1'b1, "lock below threshold");
        @(negedge i_mclk);
        i_err_control_audio_channel = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk(o_lock === 1'b0, "lock at threshold");
        i_link_detect = 1'b0;
        wr(ADDR_THR, 8'h03);
        i_link_detect = 1'b1;
        repeat (2) @(negedge i_mclk);
        chk(o_lock === 1'b1, "lock regained");
        i_err_link_clock_secondary = 1'b1;
        @(negedge i_mclk);
        i_err_link_clock_secondary = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk(o_lock === 1'b0, "lock on single error");
        for (int k = 0; k < 8; k++) begin
            if (k == 6) continue;
            wr(ADDR_BC, {4'h0, k[0], 3'(k)});
            chk(o_backchannel_mode === 3'(k), "mode");
            chk(o_spi_edge_polarity === k[0], "polarity");
        end
        wr(ADDR_BC, 8'h17);
        repeat (6) @(negedge i_mclk);
        chk(o_spi_miso_oe_n === 1'b1, "miso tristate");
        go = 1'b1;
        repeat (8) @(negedge i_mclk);
        chk(o_spi_miso_oe_n === 1'b0, "miso drive selected");
        @(negedge i_spi_sclk);
        repeat (6) @(negedge i_mclk);
        chk(o_spi_miso === i_tunnel_miso, "miso data");
        go = 1'b0;
        wr(ADDR_BC, 8'h07);
        repeat (6) @(negedge i_mclk);
        chk(o_spi_miso_oe_n === 1'b0, "miso always driven");
        conclude;
    end
endmodule
bind dlc_link_config_regs dlc_link_config_regs_properties chk_props (.*);
`default_nettype wire
